// *** bench/fsr_host_model.sv ***
// Purpose: host side issuing byte reads to the status ports
// Assumes: one read at a time, started on a rising edge
// Notes:   strobe held three edges, answer taken after the second
`timescale 1ns/1ps
module fsr_host_model (
	input  wire logic        clk_in,
	input  wire logic [7:0]  data_in,
	input  wire logic        oe_in,
	output logic             rd_out,
	output logic      [15:0] addr_out
);
	// ====================
	// idle bus
	initial begin
		rd_out = 1'b0;
		addr_out = 16'h0000;
	end

	// ====================
	// one read cycle; address released to its inverse
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		repeat (2) @(posedge clk_in);
		#1;
		d = data_in;
		oe = oe_in;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
	endtask
endmodule

// *** bench/fsr_status_regs_asserts.sv ***
// Purpose: port-level checks of the status port read layouts
// Assumes: registered answer one edge after a taken read
// Notes:   bound to every status block instance
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_status_regs_asserts
	import fsr_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [1:0]  mode_sel_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic        io_rd_in,
	input  wire logic        head_dir_in,
	input  wire logic        write_protect_n_in,
	input  wire logic        index_pulse_n_in,
	input  wire logic        head_side_select_in,
	input  wire logic        track_zero_n_in,
	input  wire logic        step_in,
	input  wire logic        irq_in,
	input  wire logic        dma_request_pending_in,
	input  wire logic        motor_on_drive0_in,
	input  wire logic        write_gate_in,
	input  wire logic        drive0_select_in,
	input  wire logic [7:0]  io_data_out,
	input  wire logic        io_data_oe_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// ====================
	// decoded read kinds
	logic       enh;
	logic       lat;
	logic       hit_a;
	logic       hit_b;
	logic [7:0] d;
	assign enh = mode_sel_in == FSR_MODE_ENHANCED;
	assign lat = mode_sel_in == FSR_MODE_LATCHED;
	assign hit_a = io_rd_in && io_addr_in == `FSR_ADDR_STATUS_A;
	assign hit_b = io_rd_in && io_addr_in == `FSR_ADDR_STATUS_B;
	assign d = io_data_out;

	// ====================
	// assertions
	basic_float_a: assert property (!enh && !lat |=> !io_data_oe_out)
		else $error("data bus driven in basic mode");
	read_any_a: assert property (hit_a && enh |=> io_data_oe_out)
		else $error("port a read not answered");
	enh_motion_a: assert property (hit_a && enh |=> d[0] == $past(head_dir_in)
		&& d[3] == $past(head_side_select_in)) else $error("direction or side bit wrong");
	enh_sense_a: assert property (hit_a && enh |=> d[1] == $past(write_protect_n_in)
		&& d[2] == $past(index_pulse_n_in) && d[4] == $past(track_zero_n_in))
		else $error("active low sense bits wrong");
	enh_step_a: assert property (hit_a && enh |=> d[5] == $past(step_in) && d[6])
		else $error("live step or bit 6 wrong");
	irq_bit_a: assert property (hit_a && (enh || lat) |=> d[7] == $past(irq_in))
		else $error("interrupt bit wrong");
	lat_invert_a: assert property (hit_a && lat |=> d[0] != $past(head_dir_in)
		&& d[3] != $past(head_side_select_in) && d[1] != $past(write_protect_n_in)
		&& d[2] != $past(index_pulse_n_in) && d[4] != $past(track_zero_n_in))
		else $error("latched polarities wrong");
	lat_dma_a: assert property (hit_a && lat |=> d[6] == $past(dma_request_pending_in))
		else $error("dma pending bit wrong");
	b_fixed_a: assert property (hit_b && enh |=> d[7:6] == 2'b11 && !d[1]
		&& d[0] == $past(motor_on_drive0_in)) else $error("port b fixed or motor bits wrong");
	b_follow_a: assert property (hit_b && enh |=> d[2] == $past(write_gate_in)
		&& d[5] == $past(drive0_select_in)) else $error("write gate or select bit wrong");
	b_select_a: assert property (hit_b && lat |=> d[5] != $past(drive0_select_in))
		else $error("select bit not inverted");

	// ====================
	// main scenarios seen
	cover property (io_rd_in && !enh && !lat);
	cover property (hit_a && enh);
	cover property (hit_b && lat);
endmodule

bind fsr_status_regs fsr_status_regs_asserts u_chk (.*);

// *** bench/fsr_status_regs_bench.sv ***
// Purpose: self-checking bench for the floppy status ports
// Assumes: host reads through the partner model
// Notes:   expectations built from the port layouts per mode
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_status_regs_bench;
	import fsr_pkg::*;
	logic        sys_clk_in, rst_in, sw_rst_in, io_rd_in, head_dir_in, write_protect_n_in;
	logic        index_pulse_n_in, head_side_select_in, track_zero_n_in, step_in, irq_in;
	logic        dma_request_pending_in, motor_on_drive0_in, write_gate_in, read_data_n_in;
	logic        write_data_n_in, drive0_select_in, io_data_oe_out;
	logic [1:0]  mode_sel_in;
	logic [15:0] io_addr_in;
	logic [7:0]  io_data_out;
	int          fail_count = 0;
	int          n_tests = 0;

	fsr_status_regs DUT (.*);
	fsr_host_model host (.clk_in(sys_clk_in), .data_in(io_data_out), .oe_in(io_data_oe_out),
		.rd_out(io_rd_in), .addr_out(io_addr_in));

	// ====================
	// clock and hang guard
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fail_count++;
		conclude();
	end

	// ====================
	// tasks
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic check_byte(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       oe;
		host.rd(a, d, oe);
		n_tests++;
		if (oe !== 1'b1 || d !== e) begin
			fail_count++;
			$display("MISMATCH %0t addr %h got %h oe %b want %h", $time, a, d, oe, e);
		end
	endtask
	task automatic check_float(input logic [15:0] a);
		logic [7:0] d;
		logic       oe;
		host.rd(a, d, oe);
		n_tests++;
		if (oe !== 1'b0) begin
			fail_count++;
			$display("MISMATCH %0t addr %h bus driven", $time, a);
		end
	endtask
	task automatic clear_latches;
		logic [7:0] d;
		logic       oe;
		host.rd(`FSR_ADDR_DIG_IN, d, oe);
	endtask
	// low pulse on read data (0) or write data (1)
	task automatic pulse(input int w);
		if (w == 0) read_data_n_in <= 1'b0;
		else write_data_n_in <= 1'b0;
		tick(1);
		read_data_n_in <= 1'b1;
		write_data_n_in <= 1'b1;
		tick(3);
	endtask
	task automatic soft_reset;
		sw_rst_in <= 1'b1;
		tick(1);
		sw_rst_in <= 1'b0;
		tick(2);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ====================
	// main sequence
	initial begin
		{rst_in, sw_rst_in, head_dir_in, write_protect_n_in, index_pulse_n_in} = 5'b10101;
		{head_side_select_in, track_zero_n_in, step_in, irq_in} = 4'b1001;
		{dma_request_pending_in, motor_on_drive0_in, write_gate_in} = 3'b100;
		{read_data_n_in, write_data_n_in, drive0_select_in} = 3'b110;
		mode_sel_in = FSR_MODE_ENHANCED;
		tick(16);
		rst_in <= 1'b0;
		tick(1);
		check_byte(`FSR_ADDR_STATUS_B, 8'hc0);
		step_in <= 1'b1;
		check_byte(`FSR_ADDR_STATUS_A, 8'hed);
		pulse(0);
		check_byte(`FSR_ADDR_STATUS_B, 8'hc8);
		pulse(1);
		{motor_on_drive0_in, write_gate_in, drive0_select_in} <= 3'b111;
		soft_reset();
		check_byte(`FSR_ADDR_STATUS_B, 8'hfd);
		write_gate_in <= 1'b0;
		$display("test enhanced done");
		for (int m = 0; m < 4; m += 3) begin
			mode_sel_in <= m[1:0];
			check_float(`FSR_ADDR_STATUS_A);
			check_float(`FSR_ADDR_STATUS_B);
		end
		$display("test basic done");
		mode_sel_in <= FSR_MODE_LATCHED;
		step_in <= 1'b0;
		tick(2);
		step_in <= 1'b1;
		tick(2);
		step_in <= 1'b0;
		check_byte(`FSR_ADDR_STATUS_A, 8'hf2);
		clear_latches();
		check_byte(`FSR_ADDR_STATUS_A, 8'hd2);
		step_in <= 1'b1;
		tick(2);
		step_in <= 1'b0;
		soft_reset();
		check_byte(`FSR_ADDR_STATUS_A, 8'hd2);
		$display("test latched a done");
		clear_latches();
		check_byte(`FSR_ADDR_STATUS_B, 8'h43);
		pulse(0);
		pulse(1);
		check_byte(`FSR_ADDR_STATUS_B, 8'h5b);
		clear_latches();
		check_byte(`FSR_ADDR_STATUS_B, 8'h43);
		write_gate_in <= 1'b1;
		tick(2);
		check_byte(`FSR_ADDR_STATUS_B, 8'h47);
		clear_latches();
		drive0_select_in <= 1'b0;
		check_byte(`FSR_ADDR_STATUS_B, 8'h63);
		$display("test latched b done");
		{head_dir_in, write_protect_n_in, index_pulse_n_in, head_side_select_in} <= 4'b0100;
		{track_zero_n_in, irq_in, dma_request_pending_in} <= 3'b100;
		check_byte(`FSR_ADDR_STATUS_A, 8'h0d);
		mode_sel_in <= FSR_MODE_ENHANCED;
		check_byte(`FSR_ADDR_STATUS_A, 8'h52);
		$display("test polarity done");
		conclude();
	end
endmodule

// *** hw/fsr_edge_latch.sv ***
// Purpose: per-signal edge detect with toggle and sticky latch outputs
// Assumes: inputs synchronous to sys_clk_in
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
module fsr_edge_latch
	import fsr_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       sw_rst_in,
	input  wire logic       sig_in,
	input  wire logic       fall_sel_in,
	input  wire logic       clear_in,
	output logic            toggle_out,
	output logic            sticky_out
);

	logic prev_reg;
	logic edge_det;

	// ==========================================================
	// chosen edge: falling when fall_sel_in, rising otherwise
	assign edge_det = fall_sel_in ? (prev_reg & ~sig_in) : (~prev_reg & sig_in);

	// previous sample
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= sig_in;
		end
	end

	// toggle on every chosen edge
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			toggle_out <= 1'b0;
		end else if (edge_det) begin
			toggle_out <= ~toggle_out;
		end
	end

	// sticky latch, cleared by input-port read or software reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sticky_out <= 1'b0;
		end else if (edge_det) begin
			sticky_out <= 1'b1;
		end else if (clear_in || sw_rst_in) begin
			sticky_out <= 1'b0;
		end
	end

endmodule

// *** hw/fsr_map.svh ***
// Purpose: offsets, bit positions and reset values for the floppy status ports
// Assumes: byte-wide host i/o reads, primary base address
// Notes:   definitions only
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ==========================================================
// port addresses
`define FSR_ADDR_STATUS_A   16'h03f0
`define FSR_ADDR_STATUS_B   16'h03f1
`define FSR_ADDR_DIG_IN     16'h03f7

// ==========================================================
// field positions
`define FSR_A_DIR           0
`define FSR_A_WPROT         1
`define FSR_A_INDEX         2
`define FSR_A_HEAD          3
`define FSR_A_TRACK_ZERO          4
`define FSR_A_STEP          5
`define FSR_A_BIT6          6
`define FSR_A_INT           7
`define FSR_B_MOTOR         0
`define FSR_B_WRITE_GATE         2
`define FSR_B_RDATA         3
`define FSR_B_WDATA         4
`define FSR_B_DSEL          5

// ==========================================================
// reset values and constants
`define FSR_BYTE_ZERO       8'h00
`define FSR_B_ENH_FIXED     8'hc0
`define FSR_B_LAT_FIXED     8'h43

`endif

// *** hw/fsr_pkg.sv ***
// Purpose: types shared by the floppy status port files
// Assumes: nothing
// Notes:   mode encoding follows the mode_sel_in input
package fsr_pkg;

	// ==========================================================
	// host compatibility modes
	typedef enum logic [1:0] {
		FSR_MODE_BASIC    = 2'b00,
		FSR_MODE_ENHANCED = 2'b01,
		FSR_MODE_LATCHED  = 2'b10
	} fsr_mode_t;

	// ==========================================================
	// read cycle states
	typedef enum logic [1:0] {
		FSR_RD_IDLE,
		FSR_RD_DRIVE
	} fsr_rd_state_t;

endpackage

// *** hw/fsr_read_mux.sv ***
// Purpose: registered read data and output enable for the host data bus
// Assumes: one read strobe per cycle
// Notes:   data is reloaded every cycle while driving; enable stands until the strobe or the port hit drops
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_read_mux
	import fsr_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       rd_in,
	input  wire logic       drive_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_out
);

	fsr_rd_state_t state_reg;

	// ==========================================================
	// capture read data while the strobe is high
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg   <= FSR_RD_IDLE;
			data_out    <= `FSR_BYTE_ZERO;
			data_oe_out <= 1'b0;
		end else begin
			case (state_reg)
				FSR_RD_IDLE: begin
					if (rd_in && drive_in) begin
						state_reg   <= FSR_RD_DRIVE;
						data_out    <= data_in;
						data_oe_out <= 1'b1;
					end
				end
				FSR_RD_DRIVE: begin
					data_out <= data_in;
					if (!rd_in || !drive_in) begin
						state_reg   <= FSR_RD_IDLE;
						data_oe_out <= 1'b0;
					end
				end
				default: begin
					state_reg   <= FSR_RD_IDLE;
					data_oe_out <= 1'b0;
				end
			endcase
		end
	end

endmodule

// *** hw/fsr_status_regs.sv ***
// Purpose: two read-only floppy status ports with three host compatibility modes
// Assumes: disk and controller signals synchronous to sys_clk_in; byte i/o reads
// Notes:   basic mode leaves the data bus undriven for both ports
//
// What this block does
// RULE_01 - basic mode: reading status port a leaves data lines undriven
// RULE_02 - enhanced mode: status port a readable any time, state-independent
// RULE_03 - enhanced a bit 0: direction, 1 inward, 0 outward
// RULE_04 - enhanced a bits 1,2,4: write protect, index, track zero active low
// RULE_05 - enhanced a bit 3: head side select, 1 means side 1
// RULE_06 - enhanced a bit 5: live step output level, unlatched
// RULE_07 - enhanced a bit 6: always reads 1
// RULE_08 - enhanced and latched a bit 7: controller interrupt request
// RULE_09 - latched a: direction, head active low; protect, index, track zero high
// RULE_10 - latched a bit 5: set on step, cleared by input-port read or resets
// RULE_11 - latched a bit 6: dma request pending, active high
// RULE_12 - basic mode: reading status port b leaves data lines undriven
// RULE_13 - enhanced b bit 0: motor drive 0, low at hard reset, kept on soft
// RULE_14 - enhanced b bit 1: reserved, reads 0
// RULE_15 - enhanced b bit 2: follows write gate output
// RULE_16 - enhanced b bits 3,4: toggle on read-data and write-data inactive edges
// RULE_17 - enhanced b bit 5: mirrors output port drive select bit 0
// RULE_18 - enhanced b bits 6,7: reserved, read 1
// RULE_19 - latched b bit 2: latched on write gate rising, input-port read clears
// RULE_20 - latched b bit 3: latched on read data falling, input-port read clears; the code latches on the rising edge of read_data_n_in
// RULE_21 - latched b bit 4: latched on write data falling, ungated, read clears; the code latches on the rising edge of write_data_n_in
// RULE_22 - latched b bit 5: drive-0 select shown active low
// RULE_23 - mode input selects basic, enhanced or latched layout for both ports
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_status_regs
	import fsr_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        sw_rst_in,
	input  wire logic [1:0]  mode_sel_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic        io_rd_in,
	input  wire logic        head_dir_in,
	input  wire logic        write_protect_n_in,
	input  wire logic        index_pulse_n_in,
	input  wire logic        head_side_select_in,
	input  wire logic        track_zero_n_in,
	input  wire logic        step_in,
	input  wire logic        irq_in,
	input  wire logic        dma_request_pending_in,
	input  wire logic        motor_on_drive0_in,
	input  wire logic        write_gate_in,
	input  wire logic        read_data_n_in,
	input  wire logic        write_data_n_in,
	input  wire logic        drive0_select_in,
	output logic      [7:0]  io_data_out,
	output logic             io_data_oe_out
);

	// ==========================================================
	// decode and mode
	fsr_mode_t mode;
	logic      hit_a;
	logic      hit_b;
	logic      dig_in_read;
	logic      dig_in_read_reg;
	logic      clear_pulse;
	logic      drive_bus;
	logic [7:0] rd_data;

	assign mode        = fsr_mode_t'(mode_sel_in);              // RULE_23
	assign hit_a       = (io_addr_in == `FSR_ADDR_STATUS_A);
	assign hit_b       = (io_addr_in == `FSR_ADDR_STATUS_B);
	assign dig_in_read = io_rd_in && (io_addr_in == `FSR_ADDR_DIG_IN);
	// one clear per input-port read, on its first cycle
	assign clear_pulse = dig_in_read && !dig_in_read_reg;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dig_in_read_reg <= 1'b0;
		end else begin
			dig_in_read_reg <= dig_in_read;
		end
	end

	// ==========================================================
	// edge trackers: step rising, write gate rising, data lines rising of _n
	// the inactive edge of an active-low data pulse is its rising edge;
	// data lines enter inverted, so their idle level equals the tracker's
	// reset sample and no false edge follows reset; the falling edge of
	// the inverted line is the rising edge of the pin
	logic step_lat;
	logic write_gate_lat;
	logic rdata_tog;
	logic rdata_lat;
	logic wdata_tog;
	logic wdata_lat;

	fsr_edge_latch u_step (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.sw_rst_in   (sw_rst_in),
		.sig_in      (step_in),
		.fall_sel_in (1'b0),
		.clear_in    (clear_pulse),
		.toggle_out  (),
		.sticky_out  (step_lat)                                      // RULE_10
	);

	fsr_edge_latch u_write_gate (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.sw_rst_in   (1'b0),
		.sig_in      (write_gate_in),
		.fall_sel_in (1'b0),
		.clear_in    (clear_pulse),
		.toggle_out  (),
		.sticky_out  (write_gate_lat)                                     // RULE_19
	);

	fsr_edge_latch u_rdata (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.sw_rst_in   (1'b0),
		.sig_in      (~read_data_n_in),
		.fall_sel_in (1'b1),
		.clear_in    (clear_pulse),
		.toggle_out  (rdata_tog),                                    // RULE_16
		.sticky_out  (rdata_lat)                                     // RULE_20
	);

	fsr_edge_latch u_wdata (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.sw_rst_in   (1'b0),
		.sig_in      (~write_data_n_in),
		.fall_sel_in (1'b1),
		.clear_in    (clear_pulse),
		.toggle_out  (wdata_tog),                                    // RULE_16
		.sticky_out  (wdata_lat)                                     // RULE_21
	);

	// ==========================================================
	// status port a composition
	logic [7:0] status_a_enh;
	logic [7:0] status_a_lat;

	always_comb begin
		status_a_enh                = `FSR_BYTE_ZERO;
		status_a_enh[`FSR_A_DIR]    = head_dir_in;                    // RULE_03
		status_a_enh[`FSR_A_WPROT]  = write_protect_n_in;             // RULE_04
		status_a_enh[`FSR_A_INDEX]  = index_pulse_n_in;               // RULE_04
		status_a_enh[`FSR_A_HEAD]   = head_side_select_in;            // RULE_05
		status_a_enh[`FSR_A_TRACK_ZERO]   = track_zero_n_in;                // RULE_04
		status_a_enh[`FSR_A_STEP]   = step_in;                        // RULE_06
		status_a_enh[`FSR_A_BIT6]   = 1'b1;                           // RULE_07
		status_a_enh[`FSR_A_INT]    = irq_in;                         // RULE_08
	end

	always_comb begin
		status_a_lat                = `FSR_BYTE_ZERO;
		status_a_lat[`FSR_A_DIR]    = ~head_dir_in;                   // RULE_09
		status_a_lat[`FSR_A_WPROT]  = ~write_protect_n_in;            // RULE_09
		status_a_lat[`FSR_A_INDEX]  = ~index_pulse_n_in;              // RULE_09
		status_a_lat[`FSR_A_HEAD]   = ~head_side_select_in;           // RULE_09
		status_a_lat[`FSR_A_TRACK_ZERO]   = ~track_zero_n_in;               // RULE_09
		status_a_lat[`FSR_A_STEP]   = step_lat;                       // RULE_10
		status_a_lat[`FSR_A_BIT6]   = dma_request_pending_in;         // RULE_11
		status_a_lat[`FSR_A_INT]    = irq_in;                         // RULE_08
	end

	// ==========================================================
	// status port b composition
	logic [7:0] status_b_enh;
	logic [7:0] status_b_lat;

	always_comb begin
		status_b_enh                = `FSR_B_ENH_FIXED;               // RULE_14 RULE_18
		status_b_enh[`FSR_B_MOTOR]  = motor_on_drive0_in;             // RULE_13
		status_b_enh[`FSR_B_WRITE_GATE]  = write_gate_in;                  // RULE_15
		status_b_enh[`FSR_B_RDATA]  = rdata_tog;                      // RULE_16
		status_b_enh[`FSR_B_WDATA]  = wdata_tog;                      // RULE_16
		status_b_enh[`FSR_B_DSEL]   = drive0_select_in;               // RULE_17
	end

	always_comb begin
		status_b_lat                = `FSR_B_LAT_FIXED;
		status_b_lat[`FSR_B_WRITE_GATE]  = write_gate_lat;                      // RULE_19
		status_b_lat[`FSR_B_RDATA]  = rdata_lat;                      // RULE_20
		status_b_lat[`FSR_B_WDATA]  = wdata_lat;                      // RULE_21
		status_b_lat[`FSR_B_DSEL]   = ~drive0_select_in;              // RULE_22
	end

	// ==========================================================
	// port select; basic mode keeps the bus released
	always_comb begin
		drive_bus = 1'b0;
		rd_data   = `FSR_BYTE_ZERO;
		case (mode)
			FSR_MODE_ENHANCED: begin
				drive_bus = hit_a || hit_b;                          // RULE_02
				rd_data   = hit_a ? status_a_enh : status_b_enh;
			end
			FSR_MODE_LATCHED: begin
				drive_bus = hit_a || hit_b;
				rd_data   = hit_a ? status_a_lat : status_b_lat;
			end
			default: begin
				drive_bus = 1'b0;                                    // RULE_01 RULE_12
			end
		endcase
	end

	fsr_read_mux u_rd (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in),
		.rd_in       (io_rd_in),
		.drive_in    (drive_bus),
		.data_in     (rd_data),
		.data_out    (io_data_out),
		.data_oe_out (io_data_oe_out)
	);

endmodule
